// ==== include/cpc_pkg.sv ====
/*
 * constants, field positions and carrier types shared by the converter
 * pin control register block and its self-checking bench.
 * assumes a single 125 mhz reference clock and a two-wire serial host.
 */
package cpc_pkg;

   // ------------------------------------------------------------
   // widths
   // ------------------------------------------------------------
   localparam int REG_W = 16;       // register width
   localparam int PIN_N = 8;        // configurable i/o pins
   localparam int CODE_W = 12;      // converter code width
   localparam int BYTE_W = 8;       // serial byte width

   // ------------------------------------------------------------
   // register pointers (first data byte after the address)
   // ------------------------------------------------------------
   localparam logic [7:0] PTR_GEN_CTRL = 8'h03;   // general_control
   localparam logic [7:0] PTR_ADC_SEL = 8'h04;    // analog_input_pin_select
   localparam logic [7:0] PTR_DAC_SEL = 8'h05;    // output pin select
   localparam logic [3:0] PTR_DAC_WR = 4'h1;      // upper nibble: converter write
   localparam int CH_LSB = 0;                     // channel field low bit
   localparam int CH_W = 3;                       // channel field width

   // ------------------------------------------------------------
   // general_control field positions
   // ------------------------------------------------------------
   localparam int GC_PRECH = 9;     // buffer_precharge_mode
   localparam int GC_BUF_EN = 8;    // input buffer enable
   localparam int GC_FREEZE = 7;    // pin configuration freeze
   localparam int GC_BCAST = 6;     // broadcast converter writes
   localparam int GC_ADC_SPAN = 5; // input span doubling
   localparam int GC_DAC_SPAN = 4; // output span doubling

   // ------------------------------------------------------------
   // writable masks and reset values
   // ------------------------------------------------------------
   localparam logic [15:0] GC_WR_MASK = 16'h03F0;
   localparam logic [15:0] SEL_WR_MASK = 16'h00FF;
   localparam logic [15:0] REG_RST = 16'h0000;
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;

   // ------------------------------------------------------------
   // carrier for one converter load
   // ------------------------------------------------------------
   typedef struct packed {
      logic [7:0] load;    // one bit per channel, one-cycle pulse
      logic [11:0] code;   // code loaded into every marked channel
   } cpc_dac_wr_t;

   // ------------------------------------------------------------
   // serial link states
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_ADDR = 3'b001,
      ST_ACK_A = 3'b010,
      ST_WR = 3'b011,
      ST_ACK_W = 3'b100,
      ST_RD = 3'b101,
      ST_RACK = 3'b110
   } cpc_state_t;

endpackage

// ==== rtl/cpc_sync.sv ====
/*
 * two flip-flop synchroniser for one asynchronous level.
 * assumes the input may change at any time relative to i_ref_clk.
 */
`timescale 1ns/10ps
module cpc_sync #(
   parameter logic RST_VAL = 1'b1
) (
   input wire logic i_ref_clk,
   input wire logic i_resetn,
   input wire logic i_async,
   output logic o_sync
);
   // ------------------------------------------------------------
   // stages
   // ------------------------------------------------------------
   logic meta;   // first stage, read by the second only

   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         meta <= RST_VAL;
         o_sync <= RST_VAL;
      end else begin
         meta <= i_async;
         o_sync <= meta;
      end
   end
endmodule

// ==== rtl/cpc_regs.sv ====
/*
 * converter pin control registers behind a two-wire serial slave.
 * assumes scl and sda arrive as sampled pins (open drain resolved by
 * the surroundings) and that conversion busy comes from logic on i_ref_clk.
 */
`timescale 1ns/10ps
module cpc_regs #(
   parameter logic [6:0] DEV_ADDR = 7'h10   // bus address, arbitrary default
) (
   input wire logic i_ref_clk,
   input wire logic i_resetn,
   input wire logic i_scl,                 // serial clock pin
   input wire logic i_sda,                 // serial data pin level
   output logic o_sda_out,                 // data drive level, always low
   output logic o_sda_oe,                  // high while pulling data low
   input wire logic i_conv_busy,           // a conversion is in progress
   output logic o_buf_power,               // input buffer powered
   output logic o_adc_span,                // input range doubled
   output logic o_dac_span,                // output range doubled
   output logic [7:0] o_adc_pins,          // pins acting as inputs
   output logic [7:0] o_dac_pins,          // pins acting as outputs
   output cpc_pkg::cpc_dac_wr_t o_dac_wr   // converter load pulse
);
   // ------------------------------------------------------------
   // pin sampling
   // ------------------------------------------------------------
   logic scl_s;      // synchronised clock
   logic sda_s;      // synchronised data
   logic scl_d;      // previous scl_s
   logic sda_d;      // previous sda_s
   cpc_sync #(.RST_VAL(1'b1)) u_scl_sync (
      .i_ref_clk(i_ref_clk),
      .i_resetn(i_resetn),
      .i_async(i_scl),
      .o_sync(scl_s)
   );
   cpc_sync #(.RST_VAL(1'b1)) u_sda_sync (
      .i_ref_clk(i_ref_clk),
      .i_resetn(i_resetn),
      .i_async(i_sda),
      .o_sync(sda_s)
   );
   // edges seen on the second stage only
   wire logic scl_rise = scl_s & ~scl_d;
   wire logic scl_fall = ~scl_s & scl_d;
   wire logic start_c = scl_s & scl_d & sda_d & ~sda_s;
   wire logic stop_c = scl_s & scl_d & ~sda_d & sda_s;

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   cpc_pkg::cpc_state_t state, next_state;       // link phase
   logic [3:0] bits, next_bits;                  // bits done in byte
   logic [7:0] shreg, next_shreg;                // receive shifter
   logic [15:0] rdata, next_rdata;               // transmit shifter
   logic rbyte, next_rbyte;                      // second read byte
   logic rw, next_rw;                            // read transfer
   logic [1:0] widx, next_widx;                  // 0 ptr, 1 high, 2 low
   logic [7:0] ptr, next_ptr;                    // register pointer
   logic [7:0] whi, next_whi;                    // held high byte
   logic [15:0] gc, next_gc;                     // general_control
   logic [15:0] adc_sel, next_adc_sel;           // input pin select
   logic [15:0] dac_sel, next_dac_sel;           // output pin select
   logic sda_oe, next_sda_oe;                    // data pull low
   logic buf_pw, next_buf_pw;                    // buffer power
   cpc_pkg::cpc_dac_wr_t dac_wr, next_dac_wr;    // load pulse

   // read mux: unknown pointers read as zero
   wire logic [15:0] rd_word = (ptr == cpc_pkg::PTR_GEN_CTRL) ? gc :
                               (ptr == cpc_pkg::PTR_ADC_SEL) ? adc_sel :
                               (ptr == cpc_pkg::PTR_DAC_SEL) ? dac_sel : cpc_pkg::REG_RST;

   // ------------------------------------------------------------
   // next state: link, registers, outputs
   // ------------------------------------------------------------
   always_comb begin
      logic [15:0] wd;
      wd = {whi, shreg};
      next_state = state;
      next_bits = bits;
      next_shreg = shreg;
      next_rdata = rdata;
      next_rbyte = rbyte;
      next_rw = rw;
      next_widx = widx;
      next_ptr = ptr;
      next_whi = whi;
      next_gc = gc;
      next_adc_sel = adc_sel;
      next_dac_sel = dac_sel;
      next_sda_oe = sda_oe;
      next_dac_wr = dac_wr;
      next_dac_wr.load = '0;   // load is a one-cycle pulse
      // buffer on when enabled; in precharge mode only while busy
      next_buf_pw = gc[cpc_pkg::GC_BUF_EN] &
                    (~gc[cpc_pkg::GC_PRECH] | i_conv_busy);
      if (start_c) begin
         // start or repeated start wins over everything
         next_state = cpc_pkg::ST_ADDR;
         next_bits = '0;
         next_sda_oe = 1'b0;
      end else if (stop_c) begin
         next_state = cpc_pkg::ST_IDLE;
         next_sda_oe = 1'b0;
      end else begin
         case (state)
            cpc_pkg::ST_ADDR, cpc_pkg::ST_WR: begin
               if (scl_rise) begin
                  next_shreg = {shreg[6:0], sda_s};
                  next_bits = bits + 4'h1;
               end else if (scl_fall && bits == cpc_pkg::BITS_PER_BYTE) begin
                  next_sda_oe = 1'b1;   // acknowledge
                  if (state == cpc_pkg::ST_ADDR) begin
                     // foreign address: drop off the bus quietly
                     next_rw = shreg[0];
                     next_sda_oe = (shreg[7:1] == DEV_ADDR);
                     next_state = (shreg[7:1] == DEV_ADDR) ? cpc_pkg::ST_ACK_A
                                                            : cpc_pkg::ST_IDLE;
                     next_widx = 2'h0;
                  end else begin
                     next_state = cpc_pkg::ST_ACK_W;
                     if (widx == 2'h0) begin
                        next_ptr = shreg;
                        next_widx = 2'h1;
                     end else if (widx == 2'h1) begin
                        next_whi = shreg;
                        next_widx = 2'h2;
                     end else begin
                        // word complete: commit, then allow another pair
                        next_widx = 2'h1;
                        if (ptr == cpc_pkg::PTR_GEN_CTRL)
                           next_gc = wd & cpc_pkg::GC_WR_MASK;
                        if (ptr == cpc_pkg::PTR_ADC_SEL && !gc[cpc_pkg::GC_FREEZE])
                           next_adc_sel = wd & cpc_pkg::SEL_WR_MASK;
                        if (ptr == cpc_pkg::PTR_DAC_SEL && !gc[cpc_pkg::GC_FREEZE])
                           next_dac_sel = wd & cpc_pkg::SEL_WR_MASK;
                        if (ptr[7:4] == cpc_pkg::PTR_DAC_WR) begin
                           next_dac_wr.code = wd[cpc_pkg::CODE_W-1:0];
                           if (gc[cpc_pkg::GC_BCAST])
                              next_dac_wr.load = dac_sel[7:0];
                           else
                              next_dac_wr.load = 8'h01 << ptr[cpc_pkg::CH_LSB +: cpc_pkg::CH_W];
                        end
                     end
                  end
               end
            end
            cpc_pkg::ST_ACK_A: begin
               if (scl_fall) begin
                  next_bits = '0;
                  if (rw) begin
                     // read: put first data bit on the line at once
                     next_rdata = rd_word;
                     next_rbyte = 1'b0;
                     next_sda_oe = ~rd_word[15];
                     next_state = cpc_pkg::ST_RD;
                  end else begin
                     next_sda_oe = 1'b0;
                     next_state = cpc_pkg::ST_WR;
                  end
               end
            end
            cpc_pkg::ST_ACK_W: begin
               if (scl_fall) begin
                  next_sda_oe = 1'b0;
                  next_bits = '0;
                  next_state = cpc_pkg::ST_WR;
               end
            end
            cpc_pkg::ST_RD: begin
               if (scl_fall) begin
                  next_bits = bits + 4'h1;
                  next_rdata = {rdata[14:0], 1'b0};
                  if (bits + 4'h1 == cpc_pkg::BITS_PER_BYTE) begin
                     next_sda_oe = 1'b0;   // host acknowledges
                     next_state = cpc_pkg::ST_RACK;
                  end else begin
                     next_sda_oe = ~rdata[14];
                  end
               end
            end
            cpc_pkg::ST_RACK: begin
               if (scl_rise && sda_s) begin
                  next_state = cpc_pkg::ST_IDLE;   // host refused more
               end else if (scl_fall) begin
                  // after the low byte the same register is sent again
                  next_bits = '0;
                  next_rbyte = ~rbyte;
                  next_state = cpc_pkg::ST_RD;
                  next_rdata = rbyte ? rd_word : rdata;
                  next_sda_oe = rbyte ? ~rd_word[15] : ~rdata[15];
               end
            end
            default: begin
               next_state = cpc_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         scl_d <= 1'b1;
         sda_d <= 1'b1;
         state <= cpc_pkg::ST_IDLE;
         bits <= '0;
         shreg <= '0;
         rdata <= cpc_pkg::REG_RST;
         rbyte <= 1'b0;
         rw <= 1'b0;
         widx <= 2'h0;
         ptr <= '0;
         whi <= '0;
         gc <= cpc_pkg::REG_RST;
         adc_sel <= cpc_pkg::REG_RST;
         dac_sel <= cpc_pkg::REG_RST;
         sda_oe <= 1'b0;
         buf_pw <= 1'b0;
         dac_wr <= '0;
         o_sda_out <= 1'b0;
      end else begin
         scl_d <= scl_s;
         sda_d <= sda_s;
         state <= next_state;
         bits <= next_bits;
         shreg <= next_shreg;
         rdata <= next_rdata;
         rbyte <= next_rbyte;
         rw <= next_rw;
         widx <= next_widx;
         ptr <= next_ptr;
         whi <= next_whi;
         gc <= next_gc;
         adc_sel <= next_adc_sel;
         dac_sel <= next_dac_sel;
         sda_oe <= next_sda_oe;
         buf_pw <= next_buf_pw;
         dac_wr <= next_dac_wr;
         o_sda_out <= 1'b0;   // open drain: only ever pulls low
      end
   end
   // outputs straight from flops
   assign o_sda_oe = sda_oe;
   assign o_buf_power = buf_pw;
   assign o_adc_span = gc[cpc_pkg::GC_ADC_SPAN];
   assign o_dac_span = gc[cpc_pkg::GC_DAC_SPAN];
   assign o_adc_pins = adc_sel[7:0];
   assign o_dac_pins = dac_sel[7:0];
   assign o_dac_wr = dac_wr;

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_resetn);
   a_buf_disabled_off: assert property (!gc[cpc_pkg::GC_BUF_EN] |=> !o_buf_power)
      else $error("buffer powered while disabled");
   a_buf_always_on: assert property (
      gc[cpc_pkg::GC_BUF_EN] && !gc[cpc_pkg::GC_PRECH] |=> o_buf_power)
      else $error("buffer off in continuous mode");
   a_prech_idle_off: assert property (
      gc[cpc_pkg::GC_PRECH] && !i_conv_busy |=> !o_buf_power)
      else $error("precharge buffer powered while idle");
   a_freeze_adc_sel: assert property (
      gc[cpc_pkg::GC_FREEZE] |=> $stable(o_adc_pins))
      else $error("input select changed while frozen");
   a_freeze_dac_sel: assert property (
      gc[cpc_pkg::GC_FREEZE] |=> $stable(o_dac_pins))
      else $error("output select changed while frozen");
   a_bcast_all_out: assert property ($past(gc[cpc_pkg::GC_BCAST]) &&
      o_dac_wr.load != 8'h00 |-> o_dac_wr.load == $past(o_dac_pins))
      else $error("broadcast load does not match output pins");
   a_single_chan: assert property (!$past(gc[cpc_pkg::GC_BCAST]) &&
      o_dac_wr.load != 8'h00 |-> $onehot(o_dac_wr.load) ##1 o_dac_wr.load == 8'h00)
      else $error("addressed load not a single one-cycle channel");
   a_reserved_zero: assert property ((gc & ~cpc_pkg::GC_WR_MASK) == 16'h0000 &&
      adc_sel[15:8] == 8'h00 && dac_sel[15:8] == 8'h00)
      else $error("reserved bit set");
   a_sel_needs_write: assert property ($changed(o_adc_pins) |->
      $past(state) == cpc_pkg::ST_WR && state == cpc_pkg::ST_ACK_W)
      else $error("input select changed outside a write");
   c_bcast_load: cover property (gc[cpc_pkg::GC_BCAST] ##1 o_dac_wr.load != 8'h00);
   c_single_load: cover property (!gc[cpc_pkg::GC_BCAST] ##1 o_dac_wr.load != 8'h00);
   c_read_byte: cover property (state == cpc_pkg::ST_RD ##[1:400] state == cpc_pkg::ST_RACK);
   c_frozen_write: cover property (gc[cpc_pkg::GC_FREEZE] && state == cpc_pkg::ST_ACK_W);
endmodule

// ==== testbench/cpc_host.sv ====
/*
 * behavioural two-wire serial host that drives the register block.
 * assumes a pulled-up data line resolved by the bench and a 125 mhz
 * reference clock; one bit slot is 20 clocks, a 160 ns link period.
 */
`timescale 1ns/10ps
module cpc_host (
   input wire logic i_ref_clk,
   input wire logic i_sda,
   output logic o_scl,
   output logic o_sda_oe
);
   // ------------------------------------------------------------
   // idle bus: clock parked high, data released
   // ------------------------------------------------------------
   initial begin
      o_scl = 1'b1;
      o_sda_oe = 1'b0;
   end

   // every host change lands on a falling edge of the reference clock
   task automatic tick(input int n);
      repeat (n) @(negedge i_ref_clk);
   endtask

   // start or repeated start: data falls while the clock is high
   task automatic start();
      tick(5);
      o_sda_oe = 1'b0;
      tick(5);
      o_scl = 1'b1;
      tick(10);
      o_sda_oe = 1'b1;
      tick(10);
      o_scl = 1'b0;
   endtask

   // one bit slot; data set mid-low so it is stable 5 clocks around the rise
   task automatic bit_slot(input logic drv, output logic smp);
      tick(5);
      o_sda_oe = !drv;
      tick(5);
      o_scl = 1'b1;
      tick(5);
      smp = i_sda;
      tick(5);
      o_scl = 1'b0;
   endtask

   // stop: data rises while the clock is high, clock then stays parked
   task automatic stop();
      tick(5);
      o_sda_oe = 1'b1;
      tick(5);
      o_scl = 1'b1;
      tick(10);
      o_sda_oe = 1'b0;
      tick(10);
   endtask

   // byte out, msb first, then the device's acknowledge slot
   task automatic send_byte(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_slot(b[i], s);
      end
      bit_slot(1'b1, s);
      ack = !s;
   endtask

   // byte in; last releases the line (nack) to end the read
   task automatic recv_byte(input logic last, output logic [7:0] b);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_slot(1'b1, b[i]);
      end
      bit_slot(last, s);
   endtask

   // full word write; ack is high only if all four bytes were taken
   task automatic write_word(input logic [6:0] addr, input logic [7:0] ptr,
         input logic [15:0] data, output logic ack);
      logic a0, a1, a2, a3;
      start();
      send_byte({addr, 1'b0}, a0);
      send_byte(ptr, a1);
      send_byte(data[15:8], a2);
      send_byte(data[7:0], a3);
      stop();
      ack = a0 & a1 & a2 & a3;
   endtask

   // pointer write, repeated start, then high and low byte back
   task automatic read_word(input logic [6:0] addr, input logic [7:0] ptr,
         output logic [15:0] data);
      logic a;
      start();
      send_byte({addr, 1'b0}, a);
      send_byte(ptr, a);
      start();
      send_byte({addr, 1'b1}, a);
      recv_byte(1'b0, data[15:8]);
      recv_byte(1'b1, data[7:0]);
      stop();
   endtask
endmodule

// ==== testbench/cpc_regs_tb.sv ====
/*
 * self-checking bench for the converter pin control registers.
 * assumes the serial host model in cpc_host.sv and a pulled-up data line.
 */
`timescale 1ns/10ps
module cpc_regs_tb;
   // ------------------------------------------------------------
   // table of plain register accesses
   // ------------------------------------------------------------
   typedef struct packed {
      logic [7:0] ptr;   // register pointer
      logic [15:0] wr;   // word written
      logic [15:0] rd;   // word expected back
      logic [2:0] flg;   // buffer power, input span, output span
      logic [7:0] ain;   // expected input pins
      logic [7:0] aout;  // expected output pins
   } cpc_row_t;
   localparam logic [6:0] DEV = 7'h10;  // bus address, arbitrary
   localparam logic [7:0] PG = cpc_pkg::PTR_GEN_CTRL;
   localparam logic [7:0] PA = cpc_pkg::PTR_ADC_SEL;
   localparam logic [7:0] PD = cpc_pkg::PTR_DAC_SEL;
   localparam cpc_row_t ROWS [10] = '{
      '{PA, 16'hFFA5, 16'h00A5, 3'h0, 8'hA5, 8'h00},
      '{PD, 16'h125A, 16'h005A, 3'h0, 8'hA5, 8'h5A},
      '{PG, 16'hFC0F, 16'h0000, 3'h0, 8'hA5, 8'h5A},
      '{PG, 16'h0120, 16'h0120, 3'h6, 8'hA5, 8'h5A},
      '{PG, 16'h0310, 16'h0310, 3'h1, 8'hA5, 8'h5A},
      '{PG, 16'h0080, 16'h0080, 3'h0, 8'hA5, 8'h5A},
      '{PA, 16'h0003, 16'h00A5, 3'h0, 8'hA5, 8'h5A},
      '{PD, 16'h00FF, 16'h005A, 3'h0, 8'hA5, 8'h5A},
      '{PG, 16'h0000, 16'h0000, 3'h0, 8'hA5, 8'h5A},
      '{8'h07, 16'hFFFF, 16'h0000, 3'h0, 8'hA5, 8'h5A}  // unknown pointer
   };

   // ------------------------------------------------------------
   // signals
   // ------------------------------------------------------------
   logic clk, resetn, busy, ack;
   logic [15:0] rd;                          // word read back
   logic scl, host_oe, dut_oe, dut_out, sda; // serial pins
   logic buf_pwr, a_span, d_span;
   logic [7:0] ain, aout;
   cpc_pkg::cpc_dac_wr_t dac_wr, last_wr;    // live and last seen load
   int error_cnt = 0, checks = 0, pulse_cnt = 0, base;
   // open-drain data line with pull-up, either party may pull it low
   assign sda = !(host_oe || (dut_oe && !dut_out));

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   cpc_regs #(.DEV_ADDR(DEV)) u_dut (.i_ref_clk(clk), .i_resetn(resetn), .i_scl(scl),
      .i_sda(sda), .o_sda_out(dut_out), .o_sda_oe(dut_oe), .i_conv_busy(busy),
      .o_buf_power(buf_pwr), .o_adc_span(a_span), .o_dac_span(d_span),
      .o_adc_pins(ain), .o_dac_pins(aout), .o_dac_wr(dac_wr));
   cpc_host u_host (.i_ref_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda_oe(host_oe));

   // count load pulses; a pulse longer than one cycle counts once per cycle
   always @(posedge clk) begin
      if (dac_wr.load !== 8'h00) begin
         last_wr <= dac_wr;
         pulse_cnt <= pulse_cnt + 1;
      end
   end

   // ------------------------------------------------------------
   // compare, report and access helpers
   // ------------------------------------------------------------
   task automatic wrap_up();
      $display("checks %0d errors %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic chk_rd(input logic [15:0] got, input logic [15:0] exp, input string what);
      checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic chk_pin(input logic [19:0] got, input logic [19:0] exp, input string what);
      checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   function automatic logic [19:0] outs();
      return {1'b0, buf_pwr, a_span, d_span, ain, aout};
   endfunction

   task automatic wr(input logic [7:0] p, input logic [15:0] d);
      u_host.write_word(DEV, p, d, ack);
      chk_pin({19'h0, ack}, 20'h1, "write ack");
   endtask

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      resetn = 1'b0;
      busy = 1'b0;
      repeat (3) @(negedge clk);
      chk_pin(outs(), 20'h0, "in reset");
      chk_pin(dac_wr, 20'h0, "load in reset");
      resetn = 1'b1;
      repeat (5) @(negedge clk);
      foreach (ROWS[i]) begin
         wr(ROWS[i].ptr, ROWS[i].wr);
         u_host.read_word(DEV, ROWS[i].ptr, rd);
         chk_rd(rd, ROWS[i].rd, "read back");
         chk_pin(outs(), {1'b0, ROWS[i].flg, ROWS[i].ain, ROWS[i].aout}, "outputs");
      end
      // precharge mode: buffer follows the conversion busy level
      wr(PG, 16'h0300);
      chk_pin({19'h0, buf_pwr}, 20'h0, "precharge idle");
      busy = 1'b1;
      repeat (3) @(negedge clk);
      chk_pin({19'h0, buf_pwr}, 20'h1, "precharge busy");
      busy = 1'b0;
      repeat (3) @(negedge clk);
      chk_pin({19'h0, buf_pwr}, 20'h0, "precharge done");
      // single channel load, channel 3 is also an output pin
      base = pulse_cnt;
      wr(8'h13, 16'h0ABC);
      chk_pin(20'(pulse_cnt - base), 20'h1, "single pulse");
      chk_pin(last_wr, {8'h08, 12'hABC}, "single load");
      // broadcast load reaches exactly the output pins
      wr(PG, 16'h0040);
      base = pulse_cnt;
      wr(8'h16, 16'h0123);
      chk_pin(20'(pulse_cnt - base), 20'h1, "broadcast pulse");
      chk_pin(last_wr, {8'h5A, 12'h123}, "broadcast load");
      // foreign address is not acknowledged and changes nothing
      u_host.write_word(DEV ^ 7'h01, PG, 16'h0020, ack);
      chk_pin({19'h0, ack}, 20'h0, "foreign address");
      chk_pin(outs(), {4'h0, 8'hA5, 8'h5A}, "foreign untouched");
      // reset in mid-run clears everything again
      resetn = 1'b0;
      repeat (2) @(negedge clk);
      chk_pin(outs(), 20'h0, "mid reset");
      resetn = 1'b1;
      repeat (5) @(negedge clk);
      u_host.read_word(DEV, PD, rd);
      chk_rd(rd, 16'h0000, "select after reset");
      wrap_up();
   end

   // run limit: a hang counts as a mismatch
   initial begin
      repeat (100000) @(posedge clk);
      error_cnt++;
      $display("CHECK FAILED %0t run limit reached", $time);
      wrap_up();
   end
endmodule
